//--- hw/flash_prog_cmd.sv
// Parallel fast programming port command interpreter.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_cmd
    import flash_prog_pkg::*;
#(
    parameter logic [15:0] erase_all_cmd = 16'h0061,
    parameter logic [15:0] set_lock_cmd = 16'h0062,
    parameter logic [15:0] clear_lock_cmd = 16'h0063,
    parameter logic [15:0] get_lock_cmd = 16'h0064,
    parameter logic [15:0] write_page_lock_cmd = 16'h0065,
    parameter logic [15:0] erase_write_lock_cmd = 16'h0066,
    // Version value is arbitrary.
    parameter logic [15:0] interface_version = 16'h0001,
    parameter int erase_hold = erase_hold_cycles,
    parameter int lock_region_shift = 13
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] mode,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    input wire logic command_strobe_n,
    input wire logic output_enable_n,
    output logic ready,
    output logic data_valid_n,
    input wire logic test_select,
    input wire logic erase_pin,
    input wire logic main_clock_active,
    output logic use_external_clock,
    output logic controller_select,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic page_flush,
    output logic full_erase,
    output logic pin_erase,
    output logic [15:0] lock_bits_zero,
    output logic [15:0] lock_bits_one,
    output logic [15:0] general_bits_zero,
    output logic [15:0] general_bits_one,
    output logic security_bit
);

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    logic [pin_bits-1:0] pin_meta;
    logic [pin_bits-1:0] pin_sync;
    wire [pin_bits-1:0] pin_raw;
    assign pin_raw = {command_strobe_n, output_enable_n, erase_pin, test_select,
                      main_clock_active, mode, data_in};

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_meta <= pin_sync_reset;
            pin_sync <= pin_sync_reset;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    wire strobe_s;
    wire oe_s;
    wire erase_s;
    wire tst_s;
    wire clk_present_s;
    wire [3:0] mode_s;
    wire [15:0] data_s;
    assign strobe_s = pin_sync[24];
    assign oe_s = pin_sync[23];
    assign erase_s = pin_sync[22];
    assign tst_s = pin_sync[21];
    assign clk_present_s = pin_sync[20];
    assign mode_s = pin_sync[19:16];
    assign data_s = pin_sync[15:0];

    // -------------------------------------------------------------------------
    // Handshake state machine
    // -------------------------------------------------------------------------
    hs_state_t state;
    logic [3:0] lat_mode;
    logic [15:0] lat_data;
    logic [15:0] cur_cmd;
    logic [31:0] addr;
    logic page_pending;
    logic [15:0] locks [0:1];
    logic [15:0] gp [0:1];
    wire [15:0] read_value;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= st_idle;
            ready <= 1'b1;
            data_valid_n <= 1'b1;
            data_oe <= 1'b0;
            data_out <= zero_argument;
            lat_mode <= command_type_code;
            lat_data <= zero_argument;
            use_external_clock <= 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    if (!strobe_s) begin
                        lat_mode <= mode_s;
                        lat_data <= data_s;
                        ready <= 1'b0;
                        use_external_clock <= clk_present_s;
                        state <= st_exec;
                    end
                end
                st_exec: begin
                    state <= st_wait;
                end
                st_wait: begin
                    if (!oe_s) begin
                        data_out <= read_value;
                        data_oe <= 1'b1;
                        data_valid_n <= 1'b0;
                        state <= st_drive;
                    end else if (strobe_s) begin
                        ready <= 1'b1;
                        state <= st_idle;
                    end
                end
                st_drive: begin
                    if (oe_s) begin
                        data_oe <= 1'b0;
                        data_valid_n <= 1'b1;
                        state <= st_wait;
                    end
                end
                default: begin
                    state <= st_idle;
                    ready <= 1'b1;
                    data_oe <= 1'b0;
                    data_valid_n <= 1'b1;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Command decode
    // -------------------------------------------------------------------------
    // A secured device still completes the handshake so the programmer never hangs,
    // but the latched lines are discarded and reads return zero.
    wire exec_go;
    wire cmd_go;
    wire arg_go;
    wire addr_low_go;
    wire addr_high_go;
    wire page_cmd;
    wire store_cmd;
    wire lock_busy;
    wire do_erase;
    wire do_set_lock;
    wire do_clear_lock;
    wire do_set_gp;
    wire do_clear_gp;
    wire do_store;
    wire region_finish;
    wire [region_bits-1:0] region;
    assign exec_go = (state == st_exec) && !security_bit;
    assign cmd_go = exec_go && (lat_mode == command_type_code);
    assign arg_go = exec_go && (lat_mode == data_phase_code);
    assign addr_low_go = exec_go && (lat_mode == address_low_phase);
    assign addr_high_go = exec_go && (lat_mode == address_high_phase);
    assign page_cmd = (cur_cmd == write_page_lock_cmd) || (cur_cmd == erase_write_lock_cmd);
    assign store_cmd = page_cmd || (cur_cmd == memory_write_cmd);
    assign lock_busy = |locks[controller_select];
    assign do_erase = arg_go && (cur_cmd == erase_all_cmd) && (lat_data == zero_argument)
                      && !lock_busy;
    assign do_set_lock = arg_go && (cur_cmd == set_lock_cmd);
    assign do_clear_lock = arg_go && (cur_cmd == clear_lock_cmd);
    assign do_set_gp = arg_go && (cur_cmd == set_general_bit_cmd);
    assign do_clear_gp = arg_go && (cur_cmd == clear_general_bit_cmd);
    assign do_store = arg_go && store_cmd;
    assign region_finish = cmd_go && page_cmd && page_pending;
    assign region = mem_addr[lock_region_shift +: region_bits];

    assign read_value = security_bit ? zero_argument :
                        (cur_cmd == get_lock_cmd) ? locks[controller_select] :
                        (cur_cmd == get_general_bit_cmd) ? gp[controller_select] :
                        (cur_cmd == get_security_cmd) ? {15'h0000, security_bit} :
                        (cur_cmd == get_version_cmd) ? interface_version :
                        zero_argument;

    // -------------------------------------------------------------------------
    // Command register, address and memory port
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cur_cmd <= zero_argument;
            page_pending <= 1'b0;
            page_flush <= 1'b0;
        end else begin
            page_flush <= region_finish;
            if (cmd_go) begin
                cur_cmd <= lat_data;
                page_pending <= 1'b0;
            end else if (do_store && page_cmd) begin
                page_pending <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            addr <= 32'h0000_0000;
            mem_write <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= zero_argument;
        end else begin
            mem_write <= do_store;
            if (addr_low_go) begin
                addr[15:0] <= lat_data;
            end else if (addr_high_go) begin
                addr[31:16] <= lat_data;
            end else if (do_store) begin
                mem_addr <= addr;
                mem_wdata <= lat_data;
                addr <= addr + address_step;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Controller select, security and full erase
    // -------------------------------------------------------------------------
    logic [1:0] strap_wait;
    logic erase_armed;
    logic [22:0] hold_cnt;
    wire hold_done;
    assign hold_done = erase_armed && erase_s && (hold_cnt == 23'(erase_hold - 1));

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            controller_select <= 1'b0;
            security_bit <= 1'b0;
            full_erase <= 1'b0;
        end else begin
            full_erase <= do_erase;
            if (arg_go && cur_cmd == select_controller_cmd) begin
                if (lat_data == select_zero_value) begin
                    controller_select <= 1'b0;
                end else if (lat_data == select_one_value) begin
                    controller_select <= 1'b1;
                end
            end
            // Only controller zero holds the security bit.
            if (hold_done) begin
                security_bit <= 1'b0;
            end else if (arg_go && cur_cmd == set_security_cmd && !controller_select
                         && lat_data == zero_argument) begin
                security_bit <= 1'b1;
            end
        end
    end

    // The test select strap is taken once the synchroniser has filled after reset.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            strap_wait <= 2'h0;
            erase_armed <= 1'b0;
        end else if (strap_wait != strap_delay) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait + 2'h1 == strap_delay) begin
                erase_armed <= !tst_s;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hold_cnt <= 23'h000000;
            pin_erase <= 1'b0;
        end else begin
            pin_erase <= hold_done;
            if (!erase_armed || !erase_s) begin
                hold_cnt <= 23'h000000;
            end else if (hold_cnt != 23'(erase_hold)) begin
                hold_cnt <= hold_cnt + 23'h000001;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Lock and general bits per controller
    // -------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : ctl
            wire here;
            assign here = (controller_select == 1'(g));
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    locks[g] <= mask_clear;
                    gp[g] <= mask_clear;
                end else if (hold_done) begin
                    locks[g] <= mask_clear;
                    gp[g] <= mask_clear;
                end else if (here) begin
                    if (do_erase) begin
                        locks[g] <= mask_clear;
                        gp[g] <= mask_clear;
                    end else if (do_set_lock) begin
                        locks[g] <= locks[g] | lat_data;
                    end else if (do_clear_lock) begin
                        locks[g] <= locks[g] & ~lat_data;
                    end else if (region_finish) begin
                        locks[g][region] <= 1'b1;
                    end
                    if (do_set_gp) begin
                        gp[g] <= gp[g] | lat_data;
                    end else if (do_clear_gp) begin
                        gp[g] <= gp[g] & ~lat_data;
                    end
                end
            end
        end
    endgenerate

    assign lock_bits_zero = locks[0];
    assign lock_bits_one = locks[1];
    assign general_bits_zero = gp[0];
    assign general_bits_one = gp[1];

endmodule : flash_prog_cmd
`default_nettype wire

//--- hw/flash_prog_pkg.sv
// Constants, opcodes and state codes for the parallel flash programming command interpreter.
package flash_prog_pkg;

    // -------------------------------------------------------------------------
    // Handshake mode codes
    // -------------------------------------------------------------------------
    localparam logic [3:0] command_type_code = 4'h0;
    localparam logic [3:0] address_low_phase = 4'h1;
    localparam logic [3:0] address_high_phase = 4'h2;
    localparam logic [3:0] data_phase_code = 4'h5;

    // -------------------------------------------------------------------------
    // Fixed opcodes
    // -------------------------------------------------------------------------
    localparam logic [15:0] set_general_bit_cmd = 16'h0034;
    localparam logic [15:0] clear_general_bit_cmd = 16'h0044;
    localparam logic [15:0] get_general_bit_cmd = 16'h0025;
    localparam logic [15:0] set_security_cmd = 16'h0054;
    localparam logic [15:0] get_security_cmd = 16'h0035;
    localparam logic [15:0] memory_write_cmd = 16'h001F;
    localparam logic [15:0] select_controller_cmd = 16'h0016;
    localparam logic [15:0] get_version_cmd = 16'h001E;

    // -------------------------------------------------------------------------
    // Argument values and field layout
    // -------------------------------------------------------------------------
    localparam logic [15:0] zero_argument = 16'h0000;
    localparam logic [15:0] select_zero_value = 16'h0000;
    localparam logic [15:0] select_one_value = 16'h0001;
    localparam logic [15:0] mask_clear = 16'h0000;
    localparam logic [31:0] address_step = 32'h0000_0002;
    localparam int region_bits = 4;
    localparam int pin_bits = 25;
    localparam logic [24:0] pin_sync_reset = 25'h1F0_0000;
    // The strap is taken on the third edge, so the second flop holds the pin and not its reset value.
    localparam logic [1:0] strap_delay = 2'h3;

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int clock_hz = 10_000_000;
    localparam int erase_hold_ms = 220;
    localparam int erase_hold_cycles = erase_hold_ms * (clock_hz / 1000) + 1;

    // -------------------------------------------------------------------------
    // Handshake states
    // -------------------------------------------------------------------------
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_exec = 4'h2,
        st_wait = 4'h4,
        st_drive = 4'h8
    } hs_state_t;

endpackage : flash_prog_pkg

//--- verif/flash_prog_props.sv
// Concurrent assertions for the parallel flash programming command interpreter.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_props
    import flash_prog_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic command_strobe_n,
    input wire logic output_enable_n,
    input wire logic ready,
    input wire logic data_valid_n,
    input wire logic data_oe,
    input wire logic use_external_clock,
    input wire logic controller_select,
    input wire logic mem_write,
    input wire logic full_erase,
    input wire logic pin_erase,
    input wire logic [15:0] lock_bits_zero,
    input wire logic [15:0] general_bits_zero,
    input wire logic security_bit
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // --------------------
    // Handshake steps
    // --------------------
    sequence strobe_taken;
        ready && $fell(command_strobe_n);
    endsequence
    sequence bus_released;
        ##[1:4] (data_valid_n && !data_oe);
    endsequence
    a_ready_drop: assert property (strobe_taken |-> ##[1:3] !ready)
        else $error("ready did not fall after the strobe");
    a_ready_held: assert property (!ready && !command_strobe_n |=> !ready)
        else $error("ready rose while the strobe was low");
    a_valid_cause: assert property ($fell(data_valid_n) |-> !output_enable_n)
        else $error("valid fell without output enable");
    a_drive_pairs: assert property (data_oe != data_valid_n)
        else $error("bus drive and valid disagree");
    a_bus_release: assert property ($rose(output_enable_n) |-> bus_released)
        else $error("bus not released after output enable rose");
    a_store_inside: assert property (mem_write |-> !ready ##1 !mem_write)
        else $error("store pulse outside a handshake");
    a_clock_copy: assert property (!ready ##1 !ready |-> $stable(use_external_clock))
        else $error("clock choice changed inside a handshake");
    // --------------------
    // Erase and protection
    // --------------------
    a_erase_unlocked: assert property (full_erase && !controller_select |->
        $past(lock_bits_zero, 3) == mask_clear) else $error("erase accepted while locked");
    a_erase_clears: assert property (full_erase && !controller_select |->
        ##[0:2] (lock_bits_zero == mask_clear && general_bits_zero == mask_clear))
        else $error("erase left lock or general bits set");
    // The pin erase cycle is excluded, since it legitimately clears the bits under protection.
    a_secure_freeze: assert property (security_bit ##1 (security_bit && !pin_erase) |->
        $stable(lock_bits_zero) && $stable(general_bits_zero) && !mem_write && !full_erase)
        else $error("command acted while secured");
    a_secure_owner: assert property ($rose(security_bit) |-> !controller_select)
        else $error("security set with controller one selected");
    a_pin_clears: assert property (pin_erase |->
        ##[0:1] (!security_bit && lock_bits_zero == mask_clear))
        else $error("pin erase left security or locks");
endmodule : flash_prog_props
`default_nettype wire

//--- verif/prog_model.sv
// Behavioural model of the production programmer on the parallel handshake.
`timescale 1ns/1ps
`default_nettype none
module prog_model
    import flash_prog_pkg::*;
(
    input wire logic core_clk,
    input wire logic ready,
    input wire logic data_valid_n,
    input wire logic data_oe,
    input wire logic [15:0] data_out,
    output logic [3:0] mode,
    output logic [15:0] data_in,
    output logic command_strobe_n,
    output logic output_enable_n
);
    logic drv = 1'b1;
    logic [15:0] drv_data = 16'h0000;
    logic [15:0] junk = 16'h5A5A;
    // A released bus must not keep its last value, so the idle lines change every cycle.
    assign data_in = data_oe ? data_out : (drv ? drv_data : junk);
    always @(posedge core_clk) junk <= junk + 16'h3C5B;
    initial begin
        mode = command_type_code;
        command_strobe_n = 1'b1;
        output_enable_n = 1'b1;
    end
    task automatic await(input int sel, input logic lvl);
        for (int n = 0; n < 100; n++) begin
            if ((sel == 0 ? ready : data_valid_n) === lvl) break;
            @(posedge core_clk);
        end
    endtask : await
    task automatic hs(input logic [3:0] m, input logic [15:0] d, input logic rd);
        await(0, 1'b1);
        mode <= m;
        drv_data <= d;
        drv <= 1'b1;
        @(posedge core_clk);
        command_strobe_n <= 1'b0;
        @(posedge core_clk);
        await(0, 1'b0);
        drv <= 1'b0;
        if (rd) begin
            @(posedge core_clk);
            output_enable_n <= 1'b0;
            @(posedge core_clk);
            await(1, 1'b0);
            output_enable_n <= 1'b1;
            @(posedge core_clk);
            await(1, 1'b1);
        end
        command_strobe_n <= 1'b1;
        @(posedge core_clk);
        await(0, 1'b1);
    endtask : hs
endmodule : prog_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking testbench for the parallel flash programming command interpreter.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import flash_prog_pkg::*;
;
    // --------------------
    // Design and programmer
    // --------------------
    localparam int hold = 20;
    // Version value is arbitrary.
    localparam logic [15:0] ver = 16'h00A5;
    localparam logic [15:0] op_ea = 16'h0061, op_sl = 16'h0062, op_cl = 16'h0063;
    localparam logic [15:0] op_gl = 16'h0064, op_wpl = 16'h0065, op_ewl = 16'h0066;
    logic core_clk, reset, test_select, erase_pin, main_clock_active, command_strobe_n;
    logic output_enable_n, ready, data_valid_n, data_oe, use_external_clock, controller_select;
    logic mem_write, page_flush, full_erase, pin_erase, security_bit;
    logic last_valid = 1'b1;
    logic [3:0] mode;
    logic [15:0] data_in, data_out, mem_wdata, lock_bits_zero, lock_bits_one;
    logic [15:0] general_bits_zero, general_bits_one;
    logic [31:0] mem_addr, seed;
    logic [63:0] mem_q[$], rd_q[$];
    int fails, checked, erases, flushes;
    flash_prog_cmd #(.erase_all_cmd(op_ea), .set_lock_cmd(op_sl), .clear_lock_cmd(op_cl),
        .get_lock_cmd(op_gl), .write_page_lock_cmd(op_wpl), .erase_write_lock_cmd(op_ewl),
        .interface_version(ver), .erase_hold(hold)) dut_u (.core_clk, .reset, .mode, .data_in,
        .data_out, .data_oe, .command_strobe_n, .output_enable_n, .ready, .data_valid_n,
        .test_select, .erase_pin, .main_clock_active, .use_external_clock, .controller_select,
        .mem_write, .mem_addr, .mem_wdata, .page_flush, .full_erase, .pin_erase, .lock_bits_zero,
        .lock_bits_one, .general_bits_zero, .general_bits_one, .security_bit);
    prog_model prog_u (.core_clk, .ready, .data_valid_n, .data_oe, .data_out, .mode, .data_in,
        .command_strobe_n, .output_enable_n);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // --------------------
    // Helpers
    // --------------------
    function automatic logic [15:0] rnd16();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd16
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic cmd2(input logic [15:0] op, input logic [15:0] d);
        prog_u.hs(command_type_code, op, 1'b0);
        prog_u.hs(data_phase_code, d, 1'b0);
    endtask : cmd2
    task automatic rd(input logic [15:0] op, input logic [15:0] exp);
        rd_q.push_back(64'(exp));
        prog_u.hs(command_type_code, op, 1'b0);
        prog_u.hs(data_phase_code, zero_argument, 1'b1);
    endtask : rd
    task automatic store(input logic cmd, input logic [15:0] op, input logic [31:0] a, input int n);
        logic [15:0] d;
        if (cmd) prog_u.hs(command_type_code, op, 1'b0);
        prog_u.hs(address_low_phase, a[15:0], 1'b0);
        prog_u.hs(address_high_phase, a[31:16], 1'b0);
        for (int i = 0; i < n; i++) begin
            d = rnd16();
            mem_q.push_back(64'({a + 32'(2 * i), d}));
            prog_u.hs(data_phase_code, d, 1'b0);
        end
    endtask : store
    task automatic pulse_erase(input int n);
        erase_pin <= 1'b1;
        repeat (n) @(posedge core_clk);
        erase_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : pulse_erase
    // Results are matched in arrival order, so a missing or extra store shifts every later one.
    always @(posedge core_clk) begin
        if (mem_write === 1'b1) check(64'({mem_addr, mem_wdata}), mem_q.pop_front());
        if (data_valid_n === 1'b0 && last_valid === 1'b1) check(64'(data_out), rd_q.pop_front());
        if (full_erase === 1'b1) erases++;
        if (page_flush === 1'b1) flushes++;
        last_valid <= data_valid_n;
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        fails++;
        stop_test();
    end
    // --------------------
    // Scenarios
    // --------------------
    initial begin
        logic [15:0] m1, m2, lk;
        seed = 32'hB8DE;
        fails = 0;
        checked = 0;
        erases = 0;
        flushes = 0;
        reset = 1'b1;
        test_select = 1'b0;
        erase_pin = 1'b0;
        main_clock_active = 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        check({ready, data_valid_n, data_oe, controller_select, security_bit}, 5'b11000);
        rd(get_version_cmd, ver);
        check(use_external_clock, 1'b1);
        $display("test reset and version done");
        m1 = rnd16() | 16'h0001;
        m2 = rnd16() & 16'hFFFE;
        cmd2(op_sl, m1);
        cmd2(op_cl, m2);
        lk = m1 & ~m2;
        rd(op_gl, lk);
        cmd2(16'h0077, 16'hFFFF);
        cmd2(op_ea, zero_argument);
        check({erases, lock_bits_zero}, {32'h0, lk});
        $display("test lock done");
        m1 = rnd16();
        m2 = rnd16();
        cmd2(set_general_bit_cmd, m1);
        cmd2(clear_general_bit_cmd, m2);
        rd(get_general_bit_cmd, m1 & ~m2);
        $display("test general done");
        main_clock_active <= m2[0];
        cmd2(select_controller_cmd, select_one_value);
        cmd2(op_sl, m1);
        cmd2(select_controller_cmd, 16'h0002);
        check({controller_select, use_external_clock, lock_bits_one, lock_bits_zero,
            general_bits_one}, {1'b1, m2[0], m1, lk, 16'h0000});
        rd(op_gl, m1);
        cmd2(select_controller_cmd, select_zero_value);
        cmd2(op_cl, 16'hFFFF);
        cmd2(op_ea, zero_argument);
        check({erases, lock_bits_zero, general_bits_zero}, {32'h1, 32'h0});
        $display("test controller and erase done");
        store(1'b1, memory_write_cmd, {rnd16(), rnd16()}, 3);
        store(1'b0, memory_write_cmd, {rnd16(), rnd16()}, 2);
        lk = 16'h0000;
        for (int i = 0; i < 2; i++) begin
            store(1'b1, i ? op_ewl : op_wpl, 32'h0000_A000 + 32'h2000 * 32'(i), 1);
            lk |= 16'h0020 << i;
            rd(op_gl, lk);
        end
        check(flushes, 2);
        $display("test store done");
        cmd2(select_controller_cmd, select_zero_value);
        cmd2(set_security_cmd, zero_argument);
        cmd2(op_sl, 16'hFFFF);
        rd(get_security_cmd, 16'h0000);
        check({security_bit, lock_bits_zero}, {1'b1, lk});
        pulse_erase(hold / 2);
        check(security_bit, 1'b1);
        pulse_erase(hold + 8);
        check({security_bit, lock_bits_zero}, 17'h0);
        $display("test security done");
        stop_test();
    end
endmodule : testbench
bind flash_prog_cmd flash_prog_props props_u (.core_clk, .reset, .command_strobe_n,
    .output_enable_n, .ready, .data_valid_n, .data_oe, .use_external_clock, .controller_select,
    .mem_write, .full_erase, .pin_erase, .lock_bits_zero, .general_bits_zero, .security_bit);
`default_nettype wire
